// *** logic/swg_params.svh ***
`ifndef SWG_PARAMS_SVH
`define SWG_PARAMS_SVH
// register offsets on the memory-mapped register port
`define SWG_CFG_OFFSET      8'h28
`define SWG_CTRL_OFFSET     8'h2b
// count config field positions (low bit of each 3-bit field)
`define SWG_PROG_LO_LSB     0
`define SWG_PROG_HI_LSB     3
`define SWG_DATA_LO_LSB     6
`define SWG_DATA_HI_LSB     9
`define SWG_IO_LSB          12
`define SWG_XPROG_SEL_BIT   15
// multiplier ctrl field position
`define SWG_DOUBLER_BIT     0
// reset values
`define SWG_CFG_RESET       16'h7fff
`define SWG_CTRL_RESET      16'h0000
// extended program split: upper range starts and ends here
`define SWG_XPROG_HI_BASE   23'h040000
`define SWG_XPROG_HI_TOP    23'h07ffff
// largest inserted software count
`define SWG_MAX_WAIT        4'he
`endif

// *** logic/swg_pkg.sv ***
package swg_pkg;
   // external access space
   typedef enum logic [1:0] {
      SWG_SP_PROG = 2'h0,
      SWG_SP_DATA = 2'h1,
      SWG_SP_IO   = 2'h2
   } swg_space_e;
   // access sequencer, one-hot
   typedef enum logic [1:0] {
      SWG_ST_IDLE = 2'b01,
      SWG_ST_STRB = 2'b10
   } swg_state_e;
   typedef logic [3:0] swg_count_t;
endpackage : swg_pkg

// *** logic/swg_wait_gen.sv ***
// Notes on behaviour
// - software waits stretch cycles up to fourteen
// - all-zero counts gate the generator clocks off
// - low fifteen bits hold five 3-bit counts
// - one doubler bit scales counts by one/two
// - reset gives seven waits on every range
// - bits 14-12 count for all I/O accesses
// - bits 11-9 count for upper data half
// - bits 8-6 count for lower data half
// - bits 5-3 upper program range, split by select
// - bits 2-0 lower program range, split by select
// - bit 15 selects program split, resets zero
// - doubler is ctrl bit 0, resets zero
// - doubler set doubles counts, max fourteen
// - reserved ctrl bits ignore writes
`timescale 1ns/1ps
`include "swg_params.svh"
module swg_wait_gen
   import swg_pkg::*;
#(
   parameter int ADDR_W = 23
) (
   input  wire logic              CLK_IN,
   input  wire logic              SYS_RST_IN,
   // memory-mapped register port
   input  wire logic [7:0]        MMR_ADDR_IN,
   input  wire logic              MMR_WR_IN,
   input  wire logic [15:0]       MMR_WDATA_IN,
   output logic      [15:0]       MMR_RDATA_OUT,
   // external access request from the core
   input  wire logic              ACC_REQ_IN,
   input  wire logic [1:0]        ACC_SPACE_IN,
   input  wire logic [ADDR_W-1:0] ACC_ADDR_IN,
   input  wire logic              READY_IN,
   output logic                   ACC_BUSY_OUT,
   output logic                   ACC_STROBE_OUT,
   output logic                   ACC_DONE_OUT,
   output logic                   CLK_GATE_OUT
);

   logic [15:0]      cfg_reg;
   logic             doubler_reg;
   swg_state_e       state_reg;
   swg_count_t       wait_cnt_reg;
   swg_count_t       count_next;
   logic [2:0]       base_sel;
   logic             gate_now;
   logic             req_take;
   logic             cfg_hit;
   logic             ctrl_hit;

   assign cfg_hit  = MMR_ADDR_IN == `SWG_CFG_OFFSET;
   assign ctrl_hit = MMR_ADDR_IN == `SWG_CTRL_OFFSET;

   // count config register; reset loads seven on every range
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         cfg_reg <= `SWG_CFG_RESET;
      end else if (MMR_WR_IN && cfg_hit) begin
         cfg_reg <= MMR_WDATA_IN;
      end
   end

   // only the doubler is stored; reserved bits are not
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         doubler_reg <= 1'b0;
      end else if (MMR_WR_IN && ctrl_hit) begin
         doubler_reg <= MMR_WDATA_IN[`SWG_DOUBLER_BIT];
      end
   end

   // registered read-back, one cycle after the address
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         MMR_RDATA_OUT <= 16'h0000;
      end else if (cfg_hit) begin
         MMR_RDATA_OUT <= cfg_reg;
      end else if (ctrl_hit) begin
         MMR_RDATA_OUT <= {15'h0000, doubler_reg};
      end else begin
         MMR_RDATA_OUT <= 16'h0000;
      end
   end

   // pick the base count from space and address
   always_comb begin
      base_sel = cfg_reg[`SWG_IO_LSB +: 3];
      unique case (ACC_SPACE_IN)
         SWG_SP_DATA: begin
            if (ACC_ADDR_IN[15]) begin
               base_sel = cfg_reg[`SWG_DATA_HI_LSB +: 3];
            end else begin
               base_sel = cfg_reg[`SWG_DATA_LO_LSB +: 3];
            end
         end
         SWG_SP_PROG: begin
            // select clear: split on page offset; set: fixed window
            if (cfg_reg[`SWG_XPROG_SEL_BIT] ?
                (ACC_ADDR_IN >= `SWG_XPROG_HI_BASE &&
                 ACC_ADDR_IN <= `SWG_XPROG_HI_TOP) :
                ACC_ADDR_IN[15]) begin
               base_sel = cfg_reg[`SWG_PROG_HI_LSB +: 3];
            end else begin
               base_sel = cfg_reg[`SWG_PROG_LO_LSB +: 3];
            end
         end
         default: base_sel = cfg_reg[`SWG_IO_LSB +: 3];
      endcase
   end

   // doubling never passes fourteen since fields top out at seven
   assign count_next = doubler_reg ? {base_sel, 1'b0}
                                   : {1'b0, base_sel};

   // all five counts zero lets the counter clock sleep
   assign gate_now = cfg_reg[14:0] == 15'h0000;

   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         CLK_GATE_OUT <= 1'b0;
      end else begin
         CLK_GATE_OUT <= gate_now;
      end
   end

   assign req_take       = ACC_REQ_IN && state_reg == SWG_ST_IDLE;
   assign ACC_BUSY_OUT   = state_reg == SWG_ST_STRB;
   assign ACC_STROBE_OUT = state_reg == SWG_ST_STRB;
   // ends only when the count is spent and ready is seen
   assign ACC_DONE_OUT   = state_reg == SWG_ST_STRB &&
                           wait_cnt_reg == 4'h0 && READY_IN;

   // access sequencer: strobe stands for one cycle plus the waits
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state_reg <= SWG_ST_IDLE;
      end else begin
         unique case (state_reg)
            SWG_ST_IDLE: begin
               if (ACC_REQ_IN) begin
                  state_reg <= SWG_ST_STRB;
               end
            end
            SWG_ST_STRB: begin
               if (ACC_DONE_OUT) begin
                  state_reg <= SWG_ST_IDLE;
               end
            end
         endcase
      end
   end

   // wait counter; loads zero on an access while gated so it burns no toggles
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         wait_cnt_reg <= 4'h0;
      end else if (req_take) begin
         wait_cnt_reg <= gate_now ? 4'h0 : count_next;
      end else if (wait_cnt_reg != 4'h0) begin
         wait_cnt_reg <= wait_cnt_reg - 4'h1;
      end
   end

   // helper: strobe length and the count loaded for this access
   logic [4:0]  strb_len_reg;
   swg_count_t  taken_reg;
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         strb_len_reg <= 5'h00;
         taken_reg    <= 4'h0;
      end else if (req_take) begin
         strb_len_reg <= 5'h01;
         taken_reg    <= gate_now ? 4'h0 : count_next;
      end else if (ACC_STROBE_OUT && strb_len_reg != 5'h1f) begin
         strb_len_reg <= strb_len_reg + 5'h01;
      end
   end

   max_wait_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      wait_cnt_reg <= `SWG_MAX_WAIT)
      else $error("wait count above fourteen");
   gate_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      gate_now |=> CLK_GATE_OUT)
      else $error("clock gate not raised on all-zero counts");
   // a gated generator must not stretch anything
   gate_cnt_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      req_take && gate_now |=> wait_cnt_reg == 4'h0)
      else $error("gated access loaded a nonzero count");
   cfg_wr_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      MMR_WR_IN && cfg_hit |=> cfg_reg == $past(MMR_WDATA_IN))
      else $error("config write not stored");
   reset_val_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      $fell(SYS_RST_IN) |-> cfg_reg == 16'h7fff && !doubler_reg)
      else $error("reset values wrong");
   io_count_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      req_take && ACC_SPACE_IN == SWG_SP_IO && !gate_now |=>
      wait_cnt_reg == ($past(doubler_reg) ?
         {$past(cfg_reg[14:12]), 1'b0} :
         {1'b0, $past(cfg_reg[14:12])}))
      else $error("io access loaded wrong count");
   data_hi_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      req_take && ACC_SPACE_IN == SWG_SP_DATA && ACC_ADDR_IN[15] &&
      !doubler_reg |=> wait_cnt_reg == {1'b0, $past(cfg_reg[11:9])})
      else $error("upper data access loaded wrong count");
   prog_lo_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      req_take && ACC_SPACE_IN == SWG_SP_PROG && !cfg_reg[15] &&
      !ACC_ADDR_IN[15] && doubler_reg |=>
      wait_cnt_reg == {$past(cfg_reg[2:0]), 1'b0})
      else $error("lower program access loaded wrong count");
   ctrl_rd_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      ctrl_hit |=> MMR_RDATA_OUT[15:1] == 15'h0000 &&
      MMR_RDATA_OUT[0] == $past(doubler_reg))
      else $error("control read-back wrong");
   strb_len_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      ACC_DONE_OUT |-> strb_len_reg >= {1'b0, taken_reg} + 5'h01)
      else $error("strobe shorter than programmed count");
   ready_hold_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      ACC_STROBE_OUT && wait_cnt_reg == 4'h0 && !READY_IN |=>
      ACC_STROBE_OUT)
      else $error("strobe dropped while not ready");

   zero_wait_c: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      req_take && gate_now ##1 ACC_DONE_OUT);
   doubled_c: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      ACC_DONE_OUT && taken_reg == `SWG_MAX_WAIT);
   ready_stall_c: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      ACC_STROBE_OUT && wait_cnt_reg == 4'h0 && !READY_IN ##1
      ACC_DONE_OUT);

endmodule : swg_wait_gen

// *** test/swg_ready_model.sv ***
`timescale 1ns/1ps
// slow external device: holds ready low for stall_in strobe cycles
module swg_ready_model (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       strobe_in,
   input  wire logic [4:0] stall_in,
   output logic            ready_out
);
   logic [4:0] cnt_reg;
   // count strobe cycles of the current access
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg <= 5'h00;
      end else begin
         cnt_reg <= strobe_in ? cnt_reg + 5'h01 : 5'h00;
      end
   end
   // beyond fourteen waits only ready can stretch
   // line is pulled up, so it reads high outside an access
   assign ready_out = !strobe_in || (cnt_reg >= stall_in);
endmodule : swg_ready_model

// *** test/software_wait_state_generator_test.sv ***
`timescale 1ns/1ps
`include "swg_params.svh"
module software_wait_state_generator_test;
   import swg_pkg::*;
   logic        clk, rst, wr, req, rdy, busy, stb, done, gate;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata;
   logic [1:0]  space;
   logic [22:0] aadr;
   logic [4:0]  stall;
   int          n_mismatch, n_checks;
   // accesses: space, address, expected base count
   logic [1:0]  sp_t [11] = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h0, 2'h0,
                              2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
   logic [22:0] ad_t [11] = '{23'h0, 23'hffff, 23'h8000, 23'h7fff,
                              23'h18000, 23'h10000, 23'h40000,
                              23'h7ffff, 23'h3ffff, 23'h8000, 23'h80000};
   logic [3:0]  ex_t [11] = '{4'h5, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1,
                              4'h2, 4'h2, 4'h1, 4'h1, 4'h1};
   swg_wait_gen dut (.CLK_IN(clk), .SYS_RST_IN(rst), .MMR_ADDR_IN(addr),
      .MMR_WR_IN(wr), .MMR_WDATA_IN(wdata), .MMR_RDATA_OUT(rdata),
      .ACC_REQ_IN(req), .ACC_SPACE_IN(space), .ACC_ADDR_IN(aadr),
      .READY_IN(rdy), .ACC_BUSY_OUT(busy), .ACC_STROBE_OUT(stb),
      .ACC_DONE_OUT(done), .CLK_GATE_OUT(gate));
   swg_ready_model dev (.clk_in(clk), .rst_in(rst), .strobe_in(stb),
      .stall_in(stall), .ready_out(rdy));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string what, input logic [15:0] e,
                      input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk); #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk); #1;
      wr = 1'b0;
   endtask : wr_reg
   // read data is registered, so look one cycle after the address
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk); #1;
      addr = a;
      @(posedge clk); #1;
      chk("register", e, rdata);
   endtask : rd_chk
   // counts strobe cycles before the done cycle, i.e. waits inserted
   task automatic acc(input logic [1:0] s, input logic [22:0] a,
                      input logic [4:0] st, input logic [4:0] e);
      int n;
      n = 0;
      @(posedge clk); #1;
      space = s;
      aadr = a;
      stall = st;
      req = 1'b1;
      @(posedge clk); #1;
      req = 1'b0;
      while (done !== 1'b1 && n < 40) begin
         n += int'(stb === 1'b1 && busy === 1'b1);
         @(posedge clk); #1;
      end
      chk("waits", {11'h0, e}, 16'(n));
   endtask : acc
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   // whole run takes about 4 us
   initial begin
      #200000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      {rst, wr, req} = 3'b100;
      {addr, wdata, space, aadr, stall} = '0;
      {n_mismatch, n_checks} = '0;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      rd_chk(`SWG_CFG_OFFSET, 16'h7fff);
      rd_chk(`SWG_CTRL_OFFSET, 16'h0000);
      chk("gate", 16'h0000, {15'h0, gate});
      acc(SWG_SP_DATA, 23'h100, 5'h00, 5'h07);
      $display("test reset done");
      wr_reg(`SWG_CTRL_OFFSET, 16'hffff);
      rd_chk(`SWG_CTRL_OFFSET, 16'h0001);
      acc(SWG_SP_IO, 23'h0, 5'h00, 5'h0e);
      $display("test doubler done");
      wr_reg(`SWG_CFG_OFFSET, 16'h58d1);
      rd_chk(`SWG_CFG_OFFSET, 16'h58d1);
      for (int d = 0; d < 2; d++) begin
         wr_reg(`SWG_CTRL_OFFSET, 16'(d));
         for (int i = 0; i < 6; i++) begin
            acc(sp_t[i], ad_t[i], 5'h00,
                5'(ex_t[i]) << d);
         end
      end
      wr_reg(`SWG_CFG_OFFSET, 16'hd8d1);
      wr_reg(`SWG_CTRL_OFFSET, 16'h0000);
      for (int i = 6; i < 11; i++) begin
         acc(sp_t[i], ad_t[i], 5'h00, 5'(ex_t[i]));
      end
      $display("test ranges done");
      acc(SWG_SP_PROG, 23'h0, 5'h09, 5'h09);
      acc(SWG_SP_PROG, 23'h0, 5'h14, 5'h14);
      $display("test ready done");
      // a write elsewhere must leave the count config alone
      wr_reg(8'h29, 16'h1234);
      rd_chk(8'h29, 16'h0000);
      rd_chk(`SWG_CFG_OFFSET, 16'hd8d1);
      wr_reg(`SWG_CFG_OFFSET, 16'h8000);
      rd_chk(`SWG_CFG_OFFSET, 16'h8000);
      chk("gate", 16'h0001, {15'h0, gate});
      acc(SWG_SP_IO, 23'h0, 5'h00, 5'h00);
      wr_reg(`SWG_CFG_OFFSET, 16'h0001);
      rd_chk(`SWG_CFG_OFFSET, 16'h0001);
      chk("gate", 16'h0000, {15'h0, gate});
      $display("test gating done");
      // reset in mid-run must bring back seven waits and a clear doubler
      wr_reg(`SWG_CTRL_OFFSET, 16'h0001);
      @(posedge clk);
      #1 rst = 1'b1;
      @(posedge clk);
      #1 rst = 1'b0;
      rd_chk(`SWG_CFG_OFFSET, 16'h7fff);
      rd_chk(`SWG_CTRL_OFFSET, 16'h0000);
      chk("gate", 16'h0000, {15'h0, gate});
      acc(SWG_SP_PROG, 23'h8000, 5'h00, 5'h07);
      $display("test mid-run reset done");
      end_sim();
   end
endmodule : software_wait_state_generator_test
